// >>> logic/mrsp_pkg.sv
package mrsp_pkg;
	// register offsets (byte addresses)
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_BAUD    = 8'h04;
	localparam logic [7:0] ADDR_RTSON   = 8'h08;
	localparam logic [7:0] ADDR_RTSOFF  = 8'h0C;
	localparam logic [7:0] ADDR_RSPTO   = 8'h10;
	localparam logic [7:0] ADDR_CHARTO  = 8'h14;
	localparam logic [7:0] ADDR_FRMDLY  = 8'h18;
	localparam logic [7:0] ADDR_TXDATA  = 8'h1C;
	localparam logic [7:0] ADDR_RXDATA  = 8'h20;
	localparam logic [7:0] ADDR_STATUS  = 8'h24;
	localparam logic [7:0] ADDR_IRQ     = 8'h28;
	localparam logic [7:0] ADDR_MASK    = 8'h2C;
	// ctrl field positions
	localparam int CTRL_PAR_LSB  = 0;
	localparam int CTRL_STOP2    = 3;
	localparam int CTRL_FLOW_LSB = 4;
	localparam int CTRL_IF_LSB   = 6;
	localparam int CTRL_ROLE_LSB = 8;
	localparam int CTRL_RTU      = 10;
	localparam logic [31:0] CTRL_RST = 32'h0000_0400;
	// parity codes
	localparam logic [2:0] PAR_NONE  = 3'h0;
	localparam logic [2:0] PAR_ODD   = 3'h1;
	localparam logic [2:0] PAR_EVEN  = 3'h2;
	localparam logic [2:0] PAR_SPACE = 3'h3;
	localparam logic [2:0] PAR_MARK  = 3'h4;
	// flow control codes
	localparam logic [1:0] FLOW_NONE   = 2'h0;
	localparam logic [1:0] FLOW_RTSCTS = 2'h1;
	localparam logic [1:0] FLOW_DTRDSR = 2'h2;
	localparam logic [1:0] FLOW_TOGGLE = 2'h3;
	// interface code; role codes
	localparam logic [1:0] IF_RS232     = 2'h0;
	localparam logic [1:0] ROLE_RTU_SLV = 2'h0;
	// irq bits
	localparam int IRQ_TXDONE = 0;
	localparam int IRQ_RXFRM  = 1;
	localparam int IRQ_RSPTO  = 2;
	localparam int IRQ_CHARTO = 3;
	localparam int IRQ_PARERR = 4;
	localparam int IRQ_W      = 5;
	// timing
	localparam int CLK_HZ      = 20_000_000;
	localparam int MS_CYC      = CLK_HZ / 1000;
	localparam int BAUD_MIN    = 50;
	localparam int BAUD_MAX    = 921600;
	localparam logic [31:0] BAUD_RST = 32'h0000_2580;
	localparam int DLY_MAX_MS  = 100;
	localparam int RSPTO_MIN   = 10;
	localparam int RSPTO_MAX   = 120000;
	localparam int GAP_MIN     = 10;
	localparam int GAP_MAX     = 500;
	localparam logic [31:0] RSPTO_RST = 32'h0000_03E8;
	localparam int AUTO_CHARS  = 4;
endpackage

// >>> logic/mrsp_rxbuf.sv
`timescale 1ns/10ps
module mrsp_rxbuf #(
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  wire logic          i_clk,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [7:0]    i_wdata,
	input  wire logic [AW-1:0] i_raddr,
	output logic [7:0]         o_rdata
);
	logic [7:0] mem [DEPTH];
	always_ff @(posedge i_clk)
	begin
		if (i_we)
			mem[i_waddr] <= i_wdata;
		o_rdata <= mem[i_raddr];
	end
endmodule

// >>> logic/mrsp_top.sv
`timescale 1ns/10ps
// Operation
// - bit rate 50 to 921600 bps
// - parity five kinds, one or two stops
// - four flow control methods
// - rts toggle only on rs-232
// - rts on, wait on-delay, then send
// - drop rts after off-delay past last bit
// - port role governs traffic handling
// - drop request after response timeout
// - frame gap only in rtu; otherwise char gap ends the frame
// - in rtu, a char gap timeout shorter than the frame gap discards partial response
// - zero char timeout means automatic interval
// - wait frame delay; zero means automatic
module mrsp_top
#(
	parameter int BUFW = 8
) (
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RSTN,
	// register port
	input  wire logic [7:0]  I_ADDR,
	input  wire logic [31:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic [31:0]      O_RDATA,
	// serial line
	input  wire logic        I_RXD,
	input  wire logic        I_CTS,
	input  wire logic        I_DSR,
	output logic             O_TXD,
	output logic             O_RTS,
	output logic             O_DTR,
	// upstream
	output logic             O_FRM_VALID,
	output logic [BUFW:0]    O_FRM_LEN,
	output logic             O_IRQ
);
	import mrsp_pkg::*;

	typedef enum logic [4:0] {
		TX_IDLE = 5'h01, TX_RTSON = 5'h02, TX_BITS = 5'h04, TX_RTSOFF = 5'h08, TX_WAIT = 5'h10
	} mrsp_tx_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'h1, RX_BITS = 3'h2, RX_HOLD = 3'h4
	} mrsp_rx_t;

	typedef struct packed {
		logic [31:0] ctrl, baud, rtson, rtsoff, rspto, charto, frmdly;
		logic [IRQ_W-1:0] irq, mask;
		logic [31:0] rdata;
		logic [2:0] rxs1, rxs2;
		logic [BUFW-1:0] rdptr;
		mrsp_tx_t txs;
		logic [7:0] txbyte;
		logic txpend;
		logic [3:0] txbit;
		logic [11:0] txsh;
		logic [31:0] txcnt;
		logic txd, rts;
		mrsp_rx_t rxs;
		logic [3:0] rxbit;
		logic [31:0] rxtick;
		logic [10:0] rxsh;
		logic [31:0] gap;
		logic [BUFW:0] wptr;
		logic rspon;
		logic [31:0] rspcnt;
		logic fvalid;
		logic [BUFW:0] flen;
	} mrsp_st_t;

	mrsp_st_t s_ff, nxt_s;
	logic [7:0] buf_rdata;
	logic       buf_we;

	mrsp_rxbuf #(.DEPTH(1 << BUFW), .AW(BUFW)) u_buf (
		.i_clk  (I_CLK),
		.i_we   (buf_we),
		.i_waddr(s_ff.wptr[BUFW-1:0]),
		.i_wdata(s_ff.rxsh[8:1]),
		.i_raddr(nxt_s.rdptr),
		.o_rdata(buf_rdata)
	);

	logic [2:0]  par;
	logic [1:0]  flow;
	logic        rtu, rx_in, cts_in, dsr_in, go, rxbyte, par_bit, xpar;
	logic [31:0] auto_gap, chgap, frgap, bit_cyc, rate;

	always_comb
	begin
		par     = s_ff.ctrl[CTRL_PAR_LSB +: 3];
		flow    = s_ff.ctrl[CTRL_FLOW_LSB +: 2];
		rtu     = s_ff.ctrl[CTRL_RTU] && (s_ff.ctrl[CTRL_ROLE_LSB +: 2] == ROLE_RTU_SLV);
		rx_in   = s_ff.rxs2[0];
		cts_in  = s_ff.rxs2[1];
		dsr_in  = s_ff.rxs2[2];
		rate    = (s_ff.baud < 32'(BAUD_MIN)) ? 32'(BAUD_MIN) :
		          (s_ff.baud > 32'(BAUD_MAX)) ? 32'(BAUD_MAX) : s_ff.baud;
		bit_cyc = 32'(CLK_HZ) / rate;
		auto_gap = bit_cyc * 32'(11 * AUTO_CHARS);
		chgap   = (s_ff.charto == 32'h0) ? auto_gap : s_ff.charto * 32'(MS_CYC);
		frgap   = (s_ff.frmdly == 32'h0) ? auto_gap : s_ff.frmdly * 32'(MS_CYC);
		case (par)
			PAR_ODD:   par_bit = ~^s_ff.txbyte;
			PAR_EVEN:  par_bit = ^s_ff.txbyte;
			PAR_MARK:  par_bit = 1'b1;
			default:   par_bit = 1'b0;
		endcase
		case (par)
			PAR_ODD:   xpar = ~^s_ff.rxsh[9:2];
			PAR_EVEN:  xpar = ^s_ff.rxsh[9:2];
			PAR_MARK:  xpar = 1'b1;
			default:   xpar = 1'b0;
		endcase
		go = (flow == FLOW_RTSCTS) ? cts_in : 1'b1;
	end

	always_comb
	begin
		nxt_s = s_ff;
		buf_we = 1'b0;
		rxbyte = 1'b0;
		nxt_s.rxs1 = {I_DSR, I_CTS, I_RXD};
		nxt_s.rxs2 = s_ff.rxs1;
		nxt_s.rdata = 32'h0;
		if (I_WR)
		begin
			case (I_ADDR)
				ADDR_CTRL:   nxt_s.ctrl = I_WDATA;
				ADDR_BAUD:   nxt_s.baud = I_WDATA;
				ADDR_RTSON:  nxt_s.rtson = (I_WDATA > 32'(DLY_MAX_MS)) ? 32'(DLY_MAX_MS) : I_WDATA;
				ADDR_RTSOFF: nxt_s.rtsoff = (I_WDATA > 32'(DLY_MAX_MS)) ? 32'(DLY_MAX_MS) : I_WDATA;
				ADDR_RSPTO:  nxt_s.rspto = (I_WDATA < 32'(RSPTO_MIN)) ? 32'(RSPTO_MIN) :
				             (I_WDATA > 32'(RSPTO_MAX)) ? 32'(RSPTO_MAX) : I_WDATA;
				ADDR_CHARTO: nxt_s.charto = (I_WDATA > 32'(GAP_MAX)) ? 32'(GAP_MAX) : I_WDATA;
				ADDR_FRMDLY: nxt_s.frmdly = (I_WDATA > 32'(GAP_MAX)) ? 32'(GAP_MAX) : I_WDATA;
				ADDR_TXDATA:
				begin
					nxt_s.txbyte = I_WDATA[7:0];
					nxt_s.txpend = 1'b1;
				end
				ADDR_IRQ:    nxt_s.irq = s_ff.irq & ~I_WDATA[IRQ_W-1:0];
				ADDR_MASK:   nxt_s.mask = I_WDATA[IRQ_W-1:0];
				default:     ;
			endcase
		end
		if (I_RD)
		begin
			case (I_ADDR)
				ADDR_CTRL:   nxt_s.rdata = s_ff.ctrl;
				ADDR_BAUD:   nxt_s.rdata = s_ff.baud;
				ADDR_RTSON:  nxt_s.rdata = s_ff.rtson;
				ADDR_RTSOFF: nxt_s.rdata = s_ff.rtsoff;
				ADDR_RSPTO:  nxt_s.rdata = s_ff.rspto;
				ADDR_CHARTO: nxt_s.rdata = s_ff.charto;
				ADDR_FRMDLY: nxt_s.rdata = s_ff.frmdly;
				ADDR_RXDATA: nxt_s.rdata = {24'h0, buf_rdata};
				ADDR_STATUS: nxt_s.rdata = {16'h0, 7'h0, s_ff.rspon, s_ff.txs != TX_IDLE,
				                            s_ff.rts, dsr_in, cts_in, s_ff.txpend, s_ff.fvalid,
				                            s_ff.wptr != '0, s_ff.rxs == RX_BITS};
				ADDR_IRQ:    nxt_s.rdata = {27'h0, s_ff.irq};
				ADDR_MASK:   nxt_s.rdata = {27'h0, s_ff.mask};
				default:     nxt_s.rdata = 32'h0;
			endcase
		end
		if (I_RD && I_ADDR == ADDR_RXDATA)
			nxt_s.rdptr = s_ff.rdptr + 1'b1;
		nxt_s.txcnt = s_ff.txcnt + 32'h1;
		case (s_ff.txs)
			TX_IDLE:
			begin
				nxt_s.txd = 1'b1;
				if (s_ff.txpend && go)
				begin
					nxt_s.txcnt = 32'h0;
					nxt_s.txsh = {1'b1, 1'b1, par_bit, s_ff.txbyte, 1'b0};
					nxt_s.txbit = 4'h0;
					nxt_s.txpend = 1'b0;
					if (flow == FLOW_TOGGLE && s_ff.ctrl[CTRL_IF_LSB +: 2] == IF_RS232)
					begin
						nxt_s.rts = 1'b1;
						nxt_s.txs = TX_RTSON;
					end
					else
						nxt_s.txs = TX_BITS;
				end
			end
			TX_RTSON:
				if (s_ff.txcnt >= s_ff.rtson * 32'(MS_CYC))
				begin
					nxt_s.txcnt = 32'h0;
					nxt_s.txs = TX_BITS;
				end
			TX_BITS:
			begin
				nxt_s.txd = s_ff.txsh[0];
				if (s_ff.txcnt + 32'h1 >= bit_cyc)
				begin
					nxt_s.txcnt = 32'h0;
					nxt_s.txsh = {1'b1, s_ff.txsh[11:1]};
					nxt_s.txbit = s_ff.txbit + 4'h1;
					if (s_ff.txbit == 4'h8 && par == PAR_NONE)
						nxt_s.txsh = {2'b11, s_ff.txsh[11:2]};
					if (s_ff.txbit == ((par == PAR_NONE) ? 4'h9 : 4'hA) +
					    (s_ff.ctrl[CTRL_STOP2] ? 4'h1 : 4'h0))
					begin
						nxt_s.irq[IRQ_TXDONE] = 1'b1;
						nxt_s.txs = (s_ff.rts) ? TX_RTSOFF : TX_WAIT;
						nxt_s.rspon = 1'b1;
						nxt_s.rspcnt = 32'h0;
					end
				end
			end
			TX_RTSOFF:
			begin
				nxt_s.txd = 1'b1;
				if (s_ff.txcnt >= s_ff.rtsoff * 32'(MS_CYC))
				begin
					nxt_s.rts = 1'b0;
					nxt_s.txs = TX_IDLE;
				end
			end
			TX_WAIT:
			begin
				nxt_s.txd = 1'b1;
				nxt_s.txs = TX_IDLE;
			end
			default: nxt_s.txs = TX_IDLE;
		endcase
		if (flow == FLOW_RTSCTS)
			nxt_s.rts = 1'b1;
		else if (flow != FLOW_TOGGLE)
			nxt_s.rts = 1'b0;
		if (s_ff.rspon)
		begin
			nxt_s.rspcnt = s_ff.rspcnt + 32'h1;
			if (s_ff.rspcnt >= s_ff.rspto * 32'(MS_CYC))
			begin
				nxt_s.rspon = 1'b0;
				nxt_s.irq[IRQ_RSPTO] = 1'b1;
				nxt_s.wptr = '0;
			end
		end
		nxt_s.gap = s_ff.gap + 32'h1;
		case (s_ff.rxs)
			RX_IDLE:
				if (!rx_in)
				begin
					nxt_s.rxs = RX_BITS;
					nxt_s.rxtick = bit_cyc >> 1;
					nxt_s.rxbit = 4'h0;
					nxt_s.rspon = 1'b0;
				end
			RX_BITS:
			begin
				nxt_s.gap = 32'h0;
				nxt_s.rxtick = s_ff.rxtick - 32'h1;
				if (s_ff.rxtick == 32'h0)
				begin
					nxt_s.rxtick = bit_cyc - 32'h1;
					nxt_s.rxsh = {rx_in, s_ff.rxsh[10:1]};
					nxt_s.rxbit = s_ff.rxbit + 4'h1;
					if (s_ff.rxbit == ((par == PAR_NONE) ? 4'h9 : 4'hA))
					begin
						rxbyte = 1'b1;
						nxt_s.rxs = RX_IDLE;
					end
				end
			end
			default: nxt_s.rxs = RX_IDLE;
		endcase
		if (rxbyte)
		begin
			if (par == PAR_NONE)
				nxt_s.rxsh = {1'b0, rx_in, s_ff.rxsh[10:2]};
			else if (s_ff.rxsh[10] != xpar)
				nxt_s.irq[IRQ_PARERR] = 1'b1;
		end
		if (I_WR && I_ADDR == ADDR_STATUS)
			nxt_s.fvalid = 1'b0;
		if (s_ff.rxs == RX_IDLE && s_ff.wptr != '0 && rx_in)
		begin
			if (rtu && s_ff.gap >= chgap && s_ff.gap < frgap)
			begin
				nxt_s.wptr = '0;
				nxt_s.irq[IRQ_CHARTO] = 1'b1;
			end
			if (s_ff.gap >= (rtu ? frgap : chgap))
			begin
				nxt_s.fvalid = 1'b1;
				nxt_s.flen = s_ff.wptr;
				nxt_s.irq[IRQ_RXFRM] = 1'b1;
				nxt_s.rdptr = '0;
				nxt_s.wptr = '0;
			end
		end
		if (s_ff.rxs == RX_HOLD || (s_ff.rxs == RX_IDLE && s_ff.rxbit != 4'h0))
		begin
			buf_we = s_ff.wptr[BUFW] == 1'b0;
			nxt_s.wptr = s_ff.wptr + {{BUFW{1'b0}}, buf_we};
			nxt_s.rxbit = 4'h0;
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (!I_RSTN)
		begin
			s_ff <= '0;
			s_ff.ctrl <= CTRL_RST;
			s_ff.baud <= BAUD_RST;
			s_ff.rspto <= RSPTO_RST;
			s_ff.txs <= TX_IDLE;
			s_ff.rxs <= RX_IDLE;
			s_ff.txd <= 1'b1;
			s_ff.rxs1 <= 3'h7;
			s_ff.rxs2 <= 3'h7;
		end
		else
			s_ff <= nxt_s;
	end

	always_ff @(posedge I_CLK)
	begin
		if (!I_RSTN)
		begin
			O_RDATA <= 32'h0;
			O_TXD <= 1'b1;
			O_RTS <= 1'b0;
			O_DTR <= 1'b0;
			O_FRM_VALID <= 1'b0;
			O_FRM_LEN <= '0;
			O_IRQ <= 1'b0;
		end
		else
		begin
			O_RDATA <= nxt_s.rdata;
			O_TXD <= nxt_s.txd;
			O_RTS <= nxt_s.rts;
			O_DTR <= flow == FLOW_DTRDSR;
			O_FRM_VALID <= nxt_s.fvalid;
			O_FRM_LEN <= nxt_s.flen;
			O_IRQ <= |(nxt_s.irq & nxt_s.mask);
		end
	end

	rts_lead_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		s_ff.txs == TX_RTSON |-> s_ff.rts) else $error("rts low during on-delay");
	rts_off_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		s_ff.txs == TX_RTSOFF && s_ff.txcnt < s_ff.rtsoff * 32'(MS_CYC) |-> s_ff.rts)
		else $error("rts dropped early");
	tog_232_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		s_ff.txs == TX_RTSON |-> s_ff.ctrl[CTRL_IF_LSB +: 2] == IF_RS232) else $error("toggle");
	rsp_tmo_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		$fell(s_ff.rspon) && s_ff.rxs == RX_IDLE |-> s_ff.irq[IRQ_RSPTO]) else $error("rsp to");
	rsp_stop_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		s_ff.rxs == RX_BITS |-> !s_ff.rspon) else $error("timer runs in rx");
	irq_out_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		|(s_ff.irq & s_ff.mask) |-> O_IRQ) else $error("irq missing");
	txd_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		s_ff.txs == TX_IDLE ##1 s_ff.txs == TX_IDLE |-> O_TXD) else $error("txd not idle");
	baud_rng_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		bit_cyc >= 32'(CLK_HZ / BAUD_MAX)) else $error("baud");
endmodule

// >>> bench/mrsp_peer.sv
`timescale 1ns/10ps
module mrsp_peer
	import mrsp_pkg::*;
(
	// line side
	input  wire logic        i_clk,
	input  wire logic        i_txd,
	input  wire logic [2:0]  i_par,
	input  wire logic        i_stop2,
	input  wire logic [15:0] i_bit,
	output logic             o_rxd
);
	initial o_rxd = 1'b1;
	function automatic logic par_bit(input logic [7:0] d, input logic [2:0] p);
		case (p)
			PAR_ODD:  return ~^d;
			PAR_EVEN: return ^d;
			PAR_MARK: return 1'b1;
			default:  return 1'b0;
		endcase
	endfunction
	// same framing as the port
	task automatic get_char(output logic [7:0] d, output logic pb, output logic ok);
		while (i_txd !== 1'b0) @(posedge i_clk);
		repeat (i_bit / 2) @(posedge i_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (i_bit) @(posedge i_clk);
			d[i] = i_txd;
		end
		pb = 1'b0;
		if (i_par != PAR_NONE)
		begin
			repeat (i_bit) @(posedge i_clk);
			pb = i_txd;
		end
		repeat (i_bit) @(posedge i_clk);
		ok = i_txd;
		if (i_stop2)
		begin
			repeat (i_bit) @(posedge i_clk);
			ok = ok & i_txd;
		end
	endtask
	task automatic send_char(input logic [7:0] d);
		logic [11:0] f;
		f = {2'b11, par_bit(d, i_par), d, 1'b0};
		for (int i = 0; i < 12; i++)
		begin
			if (i == 9 && i_par == PAR_NONE)
				continue;
			if (i == 11 && !i_stop2)
				continue;
			@(posedge i_clk);
			o_rxd <= f[i];
			repeat (i_bit - 1) @(posedge i_clk);
		end
		@(posedge i_clk);
	endtask
endmodule

// >>> bench/tb.sv
`timescale 1ns/10ps
module tb;
	import mrsp_pkg::*;
	localparam int BIT_CYC = CLK_HZ / 100000;
	logic        I_CLK, I_RSTN, I_WR, I_RD, I_RXD, I_CTS, I_DSR;
	logic [7:0]  I_ADDR;
	logic [31:0] I_WDATA, O_RDATA, rv;
	logic        O_TXD, O_RTS, O_DTR, O_FRM_VALID, O_IRQ, pb, ok, p_stop2;
	logic [8:0]  O_FRM_LEN;
	logic [7:0]  d;
	logic [2:0]  p_par;
	int          err_total, n_compared, cnt;
	mrsp_top dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
		.I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_RXD(I_RXD), .I_CTS(I_CTS),
		.I_DSR(I_DSR), .O_TXD(O_TXD), .O_RTS(O_RTS), .O_DTR(O_DTR),
		.O_FRM_VALID(O_FRM_VALID), .O_FRM_LEN(O_FRM_LEN), .O_IRQ(O_IRQ));
	mrsp_peer peer (.i_clk(I_CLK), .i_txd(O_TXD), .i_par(p_par), .i_stop2(p_stop2),
		.i_bit(16'(BIT_CYC)), .o_rxd(I_RXD));
	initial
	begin
		I_CLK = 1'b0;
		forever #25 I_CLK = ~I_CLK;
	end
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_WDATA <= v;
		I_WR <= 1'b1;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v, output logic [31:0] q);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_WDATA <= v;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1 q = O_RDATA;
	endtask
	function automatic logic pick(input int w);
		logic [2:0] s;
		s = {O_FRM_VALID, O_TXD, O_RTS};
		return s[w];
	endfunction
	task automatic wait_on(input int w, input logic v, input int lim, output int n);
		n = 0;
		while (pick(w) !== v && n < lim)
		begin
			@(posedge I_CLK);
			n++;
		end
	endtask
	task automatic cfg(input logic [2:0] p, input logic s2, input logic [1:0] fl,
		input logic [1:0] ifc);
		p_par = p;
		p_stop2 = s2;
		wr(ADDR_CTRL, {21'h0, 1'b1, ROLE_RTU_SLV, ifc, fl, s2, p});
	endtask
	initial
	begin
		repeat (95000) @(posedge I_CLK);
		err_total++;
		report_and_stop();
	end
	initial
	begin
		{I_ADDR, I_WDATA, I_WR, I_RD, err_total, n_compared} = '0;
		{I_RSTN, I_CTS, I_DSR, p_par, p_stop2} = 7'h03;
		repeat (6) @(posedge I_CLK);
		I_RSTN <= 1'b1;
		rd(ADDR_CTRL, 32'h0, rv);
		chk("ctrl_rst", CTRL_RST, rv);
		rd(ADDR_RSPTO, 32'h0, rv);
		chk("rspto_rst", RSPTO_RST, rv);
		rd(8'h30, 32'h0, rv);
		chk("unmapped", 32'h0, rv);
		chk("idle", 2'b01, {O_RTS, O_TXD});
		$display("test reset done");
		wr(ADDR_BAUD, 32'h0001_86A0);
		wr(ADDR_RTSON, 32'h1);
		wr(ADDR_RTSOFF, 32'h0);
		cfg(PAR_EVEN, 1'b0, FLOW_TOGGLE, IF_RS232);
		wr(ADDR_TXDATA, 32'h5A);
		wait_on(0, 1'b1, 50, cnt);
		chk("rts_up", 1'b1, O_RTS);
		wait_on(1, 1'b0, MS_CYC + 50, cnt);
		chk("on_delay", 1'b1, cnt >= MS_CYC && cnt <= MS_CYC + 8);
		peer.get_char(d, pb, ok);
		chk("tx_byte", 8'h5A, d);
		chk("rts_held", 1'b1, O_RTS);
		wait_on(0, 1'b0, BIT_CYC, cnt);
		chk("rts_off", 1'b1, cnt < BIT_CYC);
		cfg(PAR_EVEN, 1'b0, FLOW_TOGGLE, 2'h1);
		wr(ADDR_TXDATA, 32'h66);
		repeat (3 * BIT_CYC) @(posedge I_CLK);
		chk("no_toggle", 1'b0, O_RTS);
		repeat (12 * BIT_CYC) @(posedge I_CLK);
		$display("test rts toggle done");
		cfg(PAR_NONE, 1'b0, FLOW_RTSCTS, IF_RS232);
		I_CTS <= 1'b0;
		wr(ADDR_TXDATA, 32'hC3);
		repeat (4 * BIT_CYC) @(posedge I_CLK);
		chk("cts_hold", 1'b1, O_TXD);
		I_CTS <= 1'b1;
		peer.get_char(d, pb, ok);
		chk("cts_byte", 8'hC3, d);
		cfg(PAR_NONE, 1'b0, FLOW_DTRDSR, IF_RS232);
		repeat (3) @(posedge I_CLK);
		chk("dtr", 1'b1, O_DTR);
		for (int p = 0; p < 5; p++)
		begin
			cfg(3'(p), p[0], FLOW_NONE, IF_RS232);
			wr(ADDR_TXDATA, 32'h31 + p);
			peer.get_char(d, pb, ok);
			chk("par_byte", 8'h31 + p, d);
			chk("par_bit", peer.par_bit(d, 3'(p)), pb);
			chk("stop", 1'b1, ok);
			repeat (3 * BIT_CYC) @(posedge I_CLK);
		end
		$display("test framing done");
		wr(ADDR_CHARTO, 32'h0);
		wr(ADDR_FRMDLY, 32'h0);
		wr(ADDR_MASK, 32'h1 << IRQ_RXFRM);
		for (int i = 0; i < 3; i++)
			peer.send_char(8'h11 * (i + 1));
		wait_on(2, 1'b1, 60 * BIT_CYC, cnt);
		chk("frm_delay", 1'b1, cnt >= 40 * BIT_CYC && cnt <= 48 * BIT_CYC);
		chk("frm_len", 3, O_FRM_LEN);
		for (int i = 0; i < 3; i++)
		begin
			rd(ADDR_RXDATA, i, rv);
			chk("rx_byte", 8'h11 * (i + 1), rv[7:0]);
		end
		chk("irq_on", 1'b1, O_IRQ);
		rd(ADDR_IRQ, 32'h0, rv);
		chk("irq_bit", 1'b1, rv[IRQ_RXFRM]);
		wr(ADDR_IRQ, 32'h1 << IRQ_RXFRM);
		wr(ADDR_STATUS, 32'h0);
		@(posedge I_CLK);
		chk("irq_off", 2'b00, {O_IRQ, O_FRM_VALID});
		$display("test receive frame done");
		report_and_stop();
	end
endmodule
